// *** design/htr_pkg.sv ***
package htr_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int SRST_TIME_MS = 15;
    // Longest time, so integer division rounds down
    localparam int SRST_CYC = CLK_HZ / 1000 * SRST_TIME_MS;
    localparam int MEAS_PER_SEC = 2;
    localparam int MEAS_CYC = CLK_HZ / MEAS_PER_SEC;
    localparam int PWM_BASE_HZ = 120;
    localparam int PWM_FRAME_CYC = CLK_HZ / PWM_BASE_HZ;
    localparam int SRST_W = 19;
    localparam int MEAS_W = 24;
    localparam int PWM_W = 18;
    localparam int PWM_FRAC_W = 12;
    localparam int PROD_W = PWM_W + PWM_FRAC_W;

    // ==========================================================
    // Bus protocol
    localparam logic [6:0] DEV_ADDR = 7'h40;
    localparam logic [7:0] CMD_SOFT_RESET = 8'hfe;
    localparam logic [7:0] CMD_CFG_WRITE = 8'he6;
    localparam logic [7:0] CMD_CFG_READ = 8'he7;
    localparam logic [7:0] CMD_T_HOLD = 8'he3;
    localparam logic [7:0] CMD_RH_HOLD = 8'he5;
    localparam logic [7:0] CMD_T_POLL = 8'hf3;
    localparam logic [7:0] CMD_RH_POLL = 8'hf5;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] IDX_LSB = 2'h1;
    localparam logic [1:0] IDX_CRC = 2'h2;
    localparam logic [1:0] IDX_MAX = 2'h3;

    // ==========================================================
    // User configuration register
    localparam logic [7:0] CFG_DEFAULT = 8'h3a;
    localparam logic [7:0] CFG_HEATER_MASK = 8'h04;
    localparam int CFG_RES_HI = 7;
    localparam int CFG_RES_LO = 0;
    localparam int CFG_RELOAD_OFF = 1;
    // Resolution code to bit count, nibble i for code i
    localparam logic [15:0] RES_RH_TBL = 16'hba8c;
    localparam logic [15:0] RES_T_TBL = 16'hbdce;

    // ==========================================================
    // Checksum and output modes
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [1:0] SEL_ANALOG = 2'h0;
    localparam logic [1:0] SEL_PWM = 2'h1;
    localparam logic [1:0] SEL_I2C = 2'h3;
    localparam logic [3:0] BITS_RH_SA = 4'ha;
    localparam logic [3:0] BITS_T_SA = 4'hc;
    localparam int ANA_W = 10;

    // ==========================================================
    // Types
    typedef struct packed {
        logic is_rh;
        logic [3:0] bits;
    } htr_meas_cmd_type;

    typedef enum logic [1:0] {S_IDLE, S_REBOOT, S_MEAS} htr_sys_state_type;

    typedef enum logic [2:0] {
        L_IDLE, L_ADDR, L_ADDR_ACK, L_RX, L_RX_ACK, L_TX, L_TX_ACK
    } htr_link_state_type;

    typedef struct packed {
        htr_sys_state_type state;
        logic [1:0] sel_s1;
        logic [1:0] sel_s2;
        logic scl_s1;
        logic scl_s2;
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic srst_s1;
        logic srst_s2;
        logic srst_seen;
        logic busy;
        logic [SRST_W-1:0] cnt;
        logic [MEAS_W-1:0] period;
        logic from_bus;
        logic cur_rh;
        logic ack_tgl;
        logic [15:0] result;
        logic [ANA_W-1:0] ana;
        logic [PWM_W-1:0] pwm_phase;
        logic [PWM_W-1:0] pwm_high;
        logic pwm_level;
        logic meas_start;
        htr_meas_cmd_type meas_cmd;
    } htr_sys_type;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        logic busy_s1;
        logic busy_s2;
        logic ack_s1;
        logic ack_s2;
        logic ack_seen;
        htr_link_state_type st;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic rw;
        logic mack;
        logic [1:0] idx;
        logic [7:0] cmd;
        logic drive;
        logic [7:0] cfg;
        logic rd_cfg;
        logic srst_pend;
        logic reboot;
        logic reboot_seen;
        logic srst_tgl;
        logic req_tgl;
        htr_meas_cmd_type req;
        logic data_ready;
        logic [15:0] res;
        logic [7:0] crc;
    } htr_link_type;

    function automatic logic [7:0] crc8_byte(logic [7:0] c, logic [7:0] b);
        logic [7:0] x;
        x = c ^ b;
        for (int i = 0; i < 8; i++) begin
            x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
        end
        return x;
    endfunction

    function automatic logic [3:0] res_bits(logic [1:0] code, logic rh);
        return rh ? RES_RH_TBL[{code, 2'b00} +: 4] : RES_T_TBL[{code, 2'b00} +: 4];
    endfunction

endpackage

// *** design/htr_readout.sv ***
`timescale 1ns/10ps
`default_nettype none

module htr_readout #(
    parameter int SRST_CYC_P = htr_pkg::SRST_CYC,
    parameter int MEAS_CYC_P = htr_pkg::MEAS_CYC,
    parameter int PWM_FRAME_P = htr_pkg::PWM_FRAME_CYC
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic link_clk,
    input wire logic [1:0] sel_pins,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic meas_start,
    output htr_pkg::htr_meas_cmd_type meas_cmd,
    input wire logic meas_done,
    input wire logic [15:0] meas_code,
    output logic [htr_pkg::ANA_W-1:0] analogue_humidity_pin,
    output logic reset_busy
);
    import htr_pkg::*;

    // ==========================================================
    // System clock domain
    htr_sys_type r, next_r;
    htr_link_type l, next_l;
    logic [1:0] link_rst_sync;
    logic link_nrst;

    function automatic logic [PWM_W-1:0] high_of(logic [PWM_FRAC_W-1:0] d);
        logic [PROD_W-1:0] p;
        p = PROD_W'(d) * PROD_W'(PWM_FRAME_P);
        return p[PROD_W-1:PWM_FRAC_W];
    endfunction
    always_comb begin
        logic rh;
        logic [PWM_FRAC_W-1:0] d;
        rh = 1'b0;
        d = '0;
        next_r = r;
        next_r.meas_start = 1'b0;
        {next_r.sel_s2, next_r.sel_s1} = {r.sel_s1, sel_pins};
        {next_r.scl_s2, next_r.scl_s1} = {r.scl_s1, scl_in};
        {next_r.req_s2, next_r.req_s1} = {r.req_s1, l.req_tgl};
        {next_r.srst_s2, next_r.srst_s1} = {r.srst_s1, l.srst_tgl};
        next_r.pwm_phase = (r.pwm_phase == PWM_W'(PWM_FRAME_P - 1)) ?
                           '0 : r.pwm_phase + 1'b1;
        next_r.pwm_level = (r.sel_s2 == SEL_PWM) &&
                           (r.pwm_phase < r.pwm_high);
        if (r.period != '0) begin
            next_r.period = r.period - 1'b1;
        end
        if (r.srst_s2 != r.srst_seen) begin
            // Drops any measurement in flight
            next_r.srst_seen = r.srst_s2;
            next_r.state = S_REBOOT;
            next_r.cnt = SRST_W'(SRST_CYC_P);
            next_r.busy = 1'b1;
        end else begin
            case (r.state)
                S_IDLE: begin
                    if (r.req_s2 != r.req_seen) begin
                        next_r.req_seen = r.req_s2;
                        if (r.sel_s2 == SEL_I2C) begin
                            next_r.meas_start = 1'b1;
                            next_r.meas_cmd = l.req;
                            next_r.cur_rh = l.req.is_rh;
                            next_r.from_bus = 1'b1;
                            next_r.state = S_MEAS;
                        end
                    end else if (r.period == '0 && (r.sel_s2 == SEL_ANALOG ||
                                 r.sel_s2 == SEL_PWM)) begin
                        rh = (r.sel_s2 == SEL_ANALOG) | r.scl_s2;
                        next_r.meas_start = 1'b1;
                        next_r.meas_cmd.is_rh = rh;
                        next_r.meas_cmd.bits = rh ? BITS_RH_SA : BITS_T_SA;
                        next_r.cur_rh = rh;
                        next_r.from_bus = 1'b0;
                        // Counter reload includes the start cycle itself
                        next_r.period = MEAS_W'(MEAS_CYC_P - 1);
                        next_r.state = S_MEAS;
                    end
                end
                S_MEAS: begin
                    if (meas_done) begin
                        next_r.state = S_IDLE;
                        if (r.from_bus) begin
                            // Low bits carry type status
                            next_r.result = {meas_code[15:2], r.cur_rh,
                                             1'b0};
                            next_r.ack_tgl = ~r.ack_tgl;
                        end else begin
                            d = r.cur_rh ? {meas_code[15:6], 2'b00}
                                         : meas_code[15:4];
                            if (r.cur_rh && r.sel_s2 == SEL_ANALOG) begin
                                next_r.ana = meas_code[15:6];
                            end
                            // Mid-frame update costs one odd pulse
                            next_r.pwm_high = high_of(d);
                        end
                    end
                end
                S_REBOOT: begin
                    if (r.cnt == '0) begin
                        next_r.busy = 1'b0;
                        next_r.period = '0;
                        next_r.state = S_IDLE;
                    end else begin
                        next_r.cnt = r.cnt - 1'b1;
                    end
                end
                default: next_r.state = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            r <= '0;
        end else if (clk_en) begin
            r <= next_r;
        end
    end
    // ==========================================================
    // Link clock domain
    always_ff @(posedge link_clk) begin
        link_rst_sync <= {link_rst_sync[0], nrst};
    end
    assign link_nrst = link_rst_sync[1];

    function automatic logic [7:0] tx_byte(htr_link_type s, logic [1:0] i);
        if (s.rd_cfg) begin
            return s.cfg;
        end else if (i == '0) begin
            return s.res[15:8];
        end else if (i == IDX_LSB) begin
            return s.res[7:0];
        end
        return s.crc;
    endfunction
    always_comb begin
        logic rise, fall, start, stop;
        logic [7:0] b, c;
        logic rh;
        rise = l.scl_s2 & ~l.scl_s3;
        fall = ~l.scl_s2 & l.scl_s3;
        start = l.scl_s2 & l.scl_s3 & l.sda_s3 & ~l.sda_s2;
        stop = l.scl_s2 & l.scl_s3 & ~l.sda_s3 & l.sda_s2;
        b = l.sh;
        c = l.cfg;
        rh = 1'b0;
        next_l = l;
        {next_l.scl_s3, next_l.scl_s2, next_l.scl_s1} =
            {l.scl_s2, l.scl_s1, scl_in};
        {next_l.sda_s3, next_l.sda_s2, next_l.sda_s1} =
            {l.sda_s2, l.sda_s1, sda_in};
        {next_l.busy_s2, next_l.busy_s1} = {l.busy_s1, r.busy};
        {next_l.ack_s2, next_l.ack_s1} = {l.ack_s1, r.ack_tgl};
        if (l.reboot && l.busy_s2) begin
            next_l.reboot_seen = 1'b1;
        end else if (l.reboot && l.reboot_seen) begin
            next_l.reboot = 1'b0;
            next_l.reboot_seen = 1'b0;
        end
        if (l.ack_s2 != l.ack_seen) begin
            // Result word is stable since before the toggle
            next_l.ack_seen = l.ack_s2;
            next_l.res = r.result;
            next_l.crc = crc8_byte(crc8_byte(CRC_INIT, r.result[15:8]),
                                   r.result[7:0]);
            next_l.data_ready = 1'b1;
        end
        if (start) begin
            next_l.st = L_ADDR;
            next_l.cnt = '0;
            next_l.drive = 1'b0;
        end else if (stop) begin
            next_l.st = L_IDLE;
            next_l.drive = 1'b0;
            if (l.srst_pend) begin
                next_l.srst_pend = 1'b0;
                next_l.srst_tgl = ~l.srst_tgl;
                next_l.reboot = 1'b1;
                next_l.reboot_seen = 1'b0;
                next_l.data_ready = 1'b0;
                next_l.rd_cfg = 1'b0;
                next_l.cfg = (CFG_DEFAULT & ~CFG_HEATER_MASK) |
                             (l.cfg & CFG_HEATER_MASK);
            end
        end else begin
            case (l.st)
                L_ADDR: begin
                    if (rise) begin
                        next_l.sh = {l.sh[6:0], l.sda_s2};
                        next_l.cnt = l.cnt + 1'b1;
                    end else if (fall && l.cnt == BYTE_BITS) begin
                        next_l.rw = l.sh[0];
                        // Busy reboot or unfinished reading: no ack
                        if (l.sh[7:1] == DEV_ADDR && !l.reboot &&
                            (!l.sh[0] || l.rd_cfg || l.data_ready)) begin
                            next_l.drive = 1'b1;
                            next_l.st = L_ADDR_ACK;
                        end else begin
                            next_l.st = L_IDLE;
                        end
                    end
                end
                L_ADDR_ACK: begin
                    if (fall) begin
                        {next_l.cnt, next_l.idx} = '0;
                        if (l.rw) begin
                            next_l.sh = tx_byte(l, '0);
                            next_l.drive = ~next_l.sh[7];
                            next_l.st = L_TX;
                        end else begin
                            next_l.drive = 1'b0;
                            next_l.st = L_RX;
                        end
                    end
                end
                L_RX: begin
                    if (rise) begin
                        next_l.sh = {l.sh[6:0], l.sda_s2};
                        next_l.cnt = l.cnt + 1'b1;
                    end else if (fall && l.cnt == BYTE_BITS) begin
                        next_l.drive = 1'b1;
                        next_l.st = L_RX_ACK;
                        if (l.idx == '0) begin
                            next_l.cmd = b;
                            next_l.rd_cfg = (b == CMD_CFG_READ);
                            if (b == CMD_SOFT_RESET) begin
                                next_l.srst_pend = 1'b1;
                            end else if (b == CMD_T_HOLD ||
                                         b == CMD_RH_HOLD ||
                                         b == CMD_T_POLL ||
                                         b == CMD_RH_POLL) begin
                                rh = (b == CMD_RH_HOLD || b == CMD_RH_POLL);
                                c = l.cfg[CFG_RELOAD_OFF] ?
                                    l.cfg : CFG_DEFAULT;
                                next_l.cfg = c;
                                next_l.data_ready = 1'b0;
                                next_l.req.is_rh = rh;
                                next_l.req.bits = res_bits(
                                    {c[CFG_RES_HI], c[CFG_RES_LO]}, rh);
                                next_l.req_tgl = ~l.req_tgl;
                            end
                        end else if (l.idx == IDX_LSB &&
                                     l.cmd == CMD_CFG_WRITE) begin
                            // Reserved bits stored as written
                            next_l.cfg = b;
                        end
                    end
                end
                L_RX_ACK: begin
                    if (fall) begin
                        {next_l.drive, next_l.cnt} = '0;
                        if (l.idx != IDX_MAX) begin
                            next_l.idx = l.idx + 1'b1;
                        end
                        next_l.st = L_RX;
                    end
                end
                L_TX: begin
                    if (rise) begin
                        next_l.cnt = l.cnt + 1'b1;
                    end else if (fall) begin
                        if (l.cnt == BYTE_BITS) begin
                            next_l.drive = 1'b0;
                            next_l.st = L_TX_ACK;
                        end else begin
                            next_l.sh = {l.sh[6:0], 1'b0};
                            next_l.drive = ~l.sh[6];
                        end
                    end
                end
                L_TX_ACK: begin
                    if (rise) begin
                        next_l.mack = ~l.sda_s2;
                    end else if (fall) begin
                        if (l.mack && (l.rd_cfg || l.idx != IDX_CRC)) begin
                            next_l.idx = l.rd_cfg ? l.idx : l.idx + 1'b1;
                            next_l.sh = tx_byte(l, next_l.idx);
                            next_l.drive = ~next_l.sh[7];
                            next_l.cnt = '0;
                            next_l.st = L_TX;
                        end else begin
                            next_l.st = L_IDLE;
                        end
                    end
                end
                default: next_l.st = L_IDLE;
            endcase
        end
    end
    always_ff @(posedge link_clk) begin
        if (!link_nrst) begin
            l <= '0;
            l.cfg <= CFG_DEFAULT;
        end else begin
            l <= next_l;
        end
    end
    // ==========================================================
    // Outputs
    assign sda_out = r.pwm_level;
    assign sda_oe = (r.sel_s2 == SEL_I2C) ? l.drive : (r.sel_s2 == SEL_PWM);
    assign meas_start = r.meas_start;
    assign meas_cmd = r.meas_cmd;
    assign analogue_humidity_pin = r.ana;
    assign reset_busy = r.busy;

endmodule
`default_nettype wire

// *** tb/htr_master.sv ***
`timescale 1ns/10ps
`default_nettype none

module htr_master (
    input wire logic link_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_m
);
    // ==========
    // Bus controller, open drain
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic hp();
        repeat (6) @(posedge link_clk);
    endtask
    task automatic start();
        sda_m <= 1'b1;
        hp();
        scl <= 1'b1;
        hp();
        sda_m <= 1'b0;
        hp();
        scl <= 1'b0;
        hp();
    endtask
    task automatic stop();
        sda_m <= 1'b0;
        hp();
        scl <= 1'b1;
        hp();
        sda_m <= 1'b1;
        hp();
    endtask
    // Ninth bit: own ack level on reads
    task automatic xfer(input logic [7:0] d, input logic nak,
        output logic [7:0] q, output logic ack);
        for (int i = 0; i < 9; i++) begin
            sda_m <= (i < 8) ? d[7 - i] : nak;
            hp();
            scl <= 1'b1;
            hp();
            hp();
            if (i < 8) q[7 - i] = sda;
            else ack = sda;
            scl <= 1'b0;
            hp();
        end
    endtask
endmodule

`default_nettype wire

// *** tb/htr_readout_checker.sv ***
`timescale 1ns/10ps
`default_nettype none

module htr_readout_checker #(
    parameter int SRST_CYC_P = 50,
    parameter int MEAS_CYC_P = 200,
    parameter int PWM_FRAME_P = 64
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [1:0] sel_pins,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic meas_start,
    input wire htr_pkg::htr_meas_cmd_type meas_cmd,
    input wire logic meas_done,
    input wire logic [15:0] meas_code,
    input wire logic [htr_pkg::ANA_W-1:0] analogue_humidity_pin,
    input wire logic reset_busy
);
    import htr_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // ==========
    // Helpers
    logic [19:0] busy_n;
    logic [27:0] gap;
    logic mode_ok;
    logic [15:0] code_q;
    always_ff @(posedge clk_sys) begin
        busy_n <= reset_busy ? busy_n + 20'h1 : 20'h0;
        gap <= meas_start ? 28'h1 : gap + 28'h1;
        mode_ok <= nrst && !sel_pins[1] && (meas_start || mode_ok);
        code_q <= meas_code;
    end

    // ==========
    // Properties
    property p_busy_len;
        $fell(reset_busy) |-> busy_n == 20'(SRST_CYC_P + 1);
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("reboot length wrong");
    property p_meas_gap;
        meas_start && mode_ok |-> gap == 28'(MEAS_CYC_P);
    endproperty
    a_meas_gap: assert property (p_meas_gap)
        else $error("start gap");
    property p_ana_cmd;
        meas_start && mode_ok && sel_pins == SEL_ANALOG
            |=> meas_cmd == {1'b1, BITS_RH_SA};
    endproperty
    a_ana_cmd: assert property (p_ana_cmd)
        else $error("ana cmd");
    property p_pwm_cmd;
        meas_start && mode_ok && sel_pins == SEL_PWM |=> meas_cmd ==
            ($past(scl_in) ? {1'b1, BITS_RH_SA} : {1'b0, BITS_T_SA});
    endproperty
    a_pwm_cmd: assert property (p_pwm_cmd)
        else $error("pwm cmd");
    property p_ana_val;
        meas_done && mode_ok && sel_pins == SEL_ANALOG
            |=> analogue_humidity_pin == code_q[15:6];
    endproperty
    a_ana_val: assert property (p_ana_val)
        else $error("ana value");
    property p_pwm_oe;
        sel_pins == SEL_PWM [*4] |-> sda_oe;
    endproperty
    a_pwm_oe: assert property (p_pwm_oe)
        else $error("pwm not driven");
    property p_ana_oe;
        sel_pins == SEL_ANALOG [*4] |-> !sda_oe;
    endproperty
    a_ana_oe: assert property (p_ana_oe)
        else $error("ana driven");
    property p_pull_low;
        sel_pins == SEL_I2C [*4] |-> !(sda_oe && sda_out);
    endproperty
    a_pull_low: assert property (p_pull_low)
        else $error("bus driven high");
    property p_reboot_idle;
        reset_busy |-> !meas_start;
    endproperty
    a_reboot_idle: assert property (p_reboot_idle)
        else $error("start in reboot");
    c_reboot: cover property ($rose(reset_busy));
    c_ana: cover property (meas_done && sel_pins == SEL_ANALOG);
    c_ack: cover property (sda_oe && sel_pins == SEL_I2C);
endmodule

bind htr_readout htr_readout_checker #(.SRST_CYC_P(SRST_CYC_P),
    .MEAS_CYC_P(MEAS_CYC_P), .PWM_FRAME_P(PWM_FRAME_P))
    htr_readout_checker_inst (.clk_sys(clk_sys), .nrst(nrst),
    .sel_pins(sel_pins), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .meas_start(meas_start), .meas_cmd(meas_cmd),
    .meas_done(meas_done), .meas_code(meas_code),
    .analogue_humidity_pin(analogue_humidity_pin),
    .reset_busy(reset_busy));

`default_nettype wire

// *** tb/tb_htr_readout.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb_htr_readout;
    import htr_pkg::*;
    localparam int SRST = 400;
    localparam int FRAME = 64;
    typedef struct packed {
        logic [7:0] cmd;
        logic [3:0] bits;
        logic [15:0] code;
    } htr_row_type;
    // Resolution code is row / 2
    localparam htr_row_type ROWS [8] = '{
        '{CMD_RH_POLL, 4'hc, 16'h6350},
        '{CMD_T_POLL, 4'he, 16'h8a1f},
        '{CMD_RH_HOLD, 4'h8, 16'hff03},
        '{CMD_T_HOLD, 4'hc, 16'h0004},
        '{CMD_RH_POLL, 4'ha, 16'h1234},
        '{CMD_T_POLL, 4'hd, 16'hfffc},
        '{CMD_RH_HOLD, 4'hb, 16'h8001},
        '{CMD_T_HOLD, 4'hb, 16'h5a5a}
    };
    logic clk_sys = 1'b0;
    logic link_clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] sel_pins = SEL_I2C;
    logic meas_done = 1'b0;
    logic [15:0] meas_code = 16'h0;
    logic scl_low = 1'b0;
    logic scl, sda_m, sda_out, sda_oe, meas_start, reset_busy, a;
    logic [7:0] q;
    htr_meas_cmd_type meas_cmd;
    logic [ANA_W-1:0] ana;
    int fail_count = 0;
    int comparisons = 0;
    // Wired-AND line with pull-up
    wire logic sda = ~(sda_oe & ~sda_out) & sda_m;
    wire logic scl_pin = scl & ~scl_low;

    always #20 clk_sys = ~clk_sys;
    always #24 link_clk = ~link_clk;
    // Front end model
    always @(posedge clk_sys) meas_done <= meas_start;

    htr_readout #(.SRST_CYC_P(SRST), .MEAS_CYC_P(200), .PWM_FRAME_P(FRAME))
        htr_readout_inst (.clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1),
        .link_clk(link_clk), .sel_pins(sel_pins), .scl_in(scl_pin),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .meas_start(meas_start), .meas_cmd(meas_cmd),
        .meas_done(meas_done), .meas_code(meas_code),
        .analogue_humidity_pin(ana), .reset_busy(reset_busy));
    htr_master htr_master_inst (.link_clk(link_clk), .sda(sda),
        .scl(scl), .sda_m(sda_m));

    // ==========
    // Tasks
    task automatic chk(input string w, input logic [15:0] e,
        input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s exp %h got %h", w, e, g);
        end
    endtask
    task automatic x(input logic [7:0] b, input logic nak);
        htr_master_inst.xfer(b, nak, q, a);
    endtask
    task automatic wr(input logic [7:0] b);
        x(b, 1'b1);
        chk("ack", 16'(a), 16'h0);
    endtask
    task automatic p();
        htr_master_inst.stop();
    endtask
    task automatic hdr(input logic [7:0] c);
        htr_master_inst.start();
        wr(8'h80);
        wr(c);
    endtask
    task automatic cfg_rd();
        hdr(CMD_CFG_READ);
        htr_master_inst.start();
        wr(8'h81);
        x(8'hff, 1'b1);
        p();
    endtask
    task automatic cfg_wr(input logic [7:0] v);
        hdr(CMD_CFG_WRITE);
        wr(v);
        p();
    endtask
    task automatic wait_start();
        int n = 0;
        while (meas_start !== 1'b1 && n < 1000) begin
            @(negedge clk_sys);
            n++;
        end
        chk("start seen", 16'(n < 1000), 16'h1);
        repeat (3) @(negedge clk_sys);
    endtask
    function automatic logic [7:0] crc(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
        end
        return c;
    endfunction
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #4_000_000;
        fail_count++;
        $display("watchdog expired");
        conclude();
    end

    // ==========
    // Main sequence
    initial begin
        htr_row_type r;
        int hi;
        int d12;
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        cfg_rd();
        chk("cfg reset", 16'(q), 16'(CFG_DEFAULT));
        htr_master_inst.start();
        x(8'h82, 1'b1);
        chk("foreign", 16'(a), 16'h1);
        p();
        $display("reset test done");
        foreach (ROWS[i]) begin
            r = ROWS[i];
            cfg_rd();
            chk("reserved", 16'(q[6:1]), 16'(CFG_DEFAULT[6:1]));
            cfg_wr({i[2], q[6:1], i[1]});
            @(posedge clk_sys);
            meas_code <= r.code;
            hdr(r.cmd);
            p();
            a = 1'b1;
            for (int n = 0; n < 20 && a === 1'b1; n++) begin
                htr_master_inst.start();
                x(8'h81, 1'b1);
            end
            chk("poll", 16'(a), 16'h0);
            chk("cmd", 16'(meas_cmd), 16'({r.cmd[2], r.bits}));
            x(8'hff, 1'b0);
            chk("msb", 16'(q), 16'(r.code[15:8]));
            x(8'hff, 1'b0);
            chk("lsb", 16'(q), 16'({r.code[7:2], r.cmd[2], 1'b0}));
            x(8'hff, 1'b1);
            chk("crc", 16'(q), 16'(crc({r.code[15:2], r.cmd[2], 1'b0})));
            p();
            $display("row %0d done", i);
        end
        cfg_wr(8'h3f);
        hdr(CMD_SOFT_RESET);
        p();
        htr_master_inst.start();
        x(8'h80, 1'b1);
        chk("reboot ack", 16'(a), 16'h1);
        p();
        // Wait out the reboot
        repeat (SRST + 20) @(posedge clk_sys);
        chk("busy", 16'(reset_busy), 16'h0);
        cfg_rd();
        chk("cfg srst", 16'(q), 16'h3e);
        $display("srst test done");
        @(posedge clk_sys);
        sel_pins <= SEL_ANALOG;
        meas_code <= 16'hb6c4;
        wait_start();
        wait_start();
        chk("ana cmd", 16'(meas_cmd), 16'({1'b1, BITS_RH_SA}));
        chk("ana", 16'(ana), 16'(10'h2db));
        $display("analogue test done");
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            sel_pins <= SEL_I2C;
            repeat (4) @(posedge clk_sys);
            sel_pins <= SEL_PWM;
            scl_low <= k[0];
            meas_code <= 16'h7a35;
            wait_start();
            wait_start();
            d12 = k ? 12'h7a3 : 12'h7a0;
            hi = 0;
            repeat (FRAME) @(negedge clk_sys) hi += int'(sda_out);
            chk("pwm cmd", 16'(meas_cmd), k ? 16'h0c : 16'h1a);
            chk("pwm high", 16'(hi), 16'((d12 * FRAME) >> 12));
            chk("pwm drive", 16'(sda_oe), 16'h1);
            $display("pwm test %0d done", k);
        end
        conclude();
    end
endmodule

`default_nettype wire
